//--- logic/rsp_pkg.sv
// Purpose: constants for the radar sensor serial configuration port
// Assumes: 200 MHz system clock, link clock sampled as an ordinary input
// Notes:
// Functional notes
// R1 - each data-in bit is captured at a rising edge of the serial clock.
// R2 - the master changes data-in at falling edges so it is stable at rise.
// R3 - on reads each data-out bit is driven at a rising edge of the clock.
// R4 - select is active low and the port acts on clock and data only then.
// R5 - a dedicated active-low port reset clears the port without the clock.
// R6 - the port reset is released 10 ns or more before the first fall.
// R7 - written values land in configuration registers setting chain modes.
// R8 - one select-low period frames one transaction in a fixed word format.
package rsp_pkg;
    // frame: 1 direction bit (1 = write), 7 address bits, 16 data bits, msb first
    localparam int unsigned ADDR_W      = 7;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned FRAME_BITS  = 24;
    localparam int unsigned NUM_REGS    = 16;
    localparam int unsigned IDX_W       = 4;
    localparam int unsigned CNT_W       = 5;
    localparam int unsigned DIR_POS     = 23;
    localparam int unsigned ADDR_MSB    = 22;
    localparam int unsigned ADDR_LSB    = 16;
    localparam int unsigned HDR_BITS    = 8;
    localparam logic [15:0] REG_RESET   = 16'h0000;
    localparam logic [6:0]  ADDR_LIMIT  = 7'h10;
    localparam int unsigned CLK_PS      = 5000;
    localparam int unsigned RST_LEAD_NS = 10;
    localparam int unsigned RST_LEAD_CYC =
        ((RST_LEAD_NS * 1000) / CLK_PS) < 1 ? 1 :
        ((RST_LEAD_NS * 1000) / CLK_PS);
    typedef enum logic [1:0] {
        RSP_IDLE = 2'b00,
        RSP_HDR  = 2'b01,
        RSP_DATA = 2'b10,
        RSP_DONE = 2'b11
    } rsp_state_type;
endpackage : rsp_pkg

//--- logic/rsp_sync.sv
// Purpose: two-flop synchroniser for one bit
// Assumes: input asynchronous to clk_i
// Notes: first flop read only by second
`timescale 1ns/1ps
`default_nettype none
module rsp_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_r;
    logic sync_r;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end
    assign sync_o = sync_r;
endmodule : rsp_sync
`default_nettype wire

//--- logic/rsp_port.sv
// Purpose: serial configuration port with register file
// Assumes: link clock far slower than clk_i (at least 8 samples a period)
// Notes: register contents leave as a flat bus for the chain logic
`timescale 1ns/1ps
`default_nettype none
module rsp_port
    import rsp_pkg::*;
(
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         port_reset_n_i,
    input  wire logic                         port_select_n_i,
    input  wire logic                         serial_clock_line_i,
    input  wire logic                         serial_in_line_i,
    output logic                              serial_out_line_o,
    output logic                              serial_out_line_oe_o,
    output logic [NUM_REGS*DATA_W-1:0]        config_o,
    output logic                              write_strobe_o
);
    ////////////////////////////////////////////////////////////////////////
    logic sclk_s;
    logic sel_n_s;
    logic sdi_s;
    logic prst_n_s;
    localparam int unsigned NSYNC = 4;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn_out;
    assign raw_in = {port_reset_n_i, serial_in_line_i,
                     port_select_n_i, serial_clock_line_i};
    assign {prst_n_s, sdi_s, sel_n_s, sclk_s} = syn_out;

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            rsp_sync u_sync (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .async_i (raw_in[g]),
                .sync_o  (syn_out[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // port reset is asynchronous to the link clock: it acts in clk_i time
    // regardless of the serial clock [R5]
    logic port_clr;
    assign port_clr = !rst_n_i || !prst_n_s; // [R5]

    logic          sclk_r;
    logic          sclk_nxt;
    rsp_state_type state_r;
    rsp_state_type state_nxt;
    logic [CNT_W-1:0]      cnt_r;
    logic [CNT_W-1:0]      cnt_nxt;
    logic [FRAME_BITS-1:0] shin_r;
    logic [FRAME_BITS-1:0] shin_nxt;
    logic [DATA_W-1:0]     shout_r;
    logic [DATA_W-1:0]     shout_nxt;
    logic                  sdo_r;
    logic                  sdo_nxt;
    logic                  oe_r;
    logic                  oe_nxt;
    logic                  wr_r;
    logic                  wr_nxt;
    logic [DATA_W-1:0]     regs_r [NUM_REGS];
    logic [FRAME_BITS-1:0] word;
    logic                  rise;

    assign rise = sclk_s && !sclk_r;
    always_comb begin
        word = {shin_r[FRAME_BITS-2:0], sdi_s};
    end

    always_comb begin
        sclk_nxt  = sclk_s;
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        shin_nxt  = shin_r;
        shout_nxt = shout_r;
        sdo_nxt   = sdo_r;
        oe_nxt    = oe_r;
        wr_nxt    = 1'b0;
        if (sel_n_s) begin
            // select high: ignore clock and data, release the out line [R4]
            state_nxt = RSP_IDLE;
            cnt_nxt   = '0;
            oe_nxt    = 1'b0;
        end else begin
            case (state_r)
                RSP_IDLE: begin
                    state_nxt = RSP_HDR; // [R8]
                    cnt_nxt   = '0;
                    oe_nxt    = 1'b1;
                    sdo_nxt   = 1'b0;
                end
                RSP_HDR, RSP_DATA: begin
                    if (rise) begin
                        // data is stable here; master moved it at fall [R1] [R2]
                        shin_nxt = word; // [R1]
                        cnt_nxt  = cnt_r + 1'b1;
                        if (state_r == RSP_DATA) begin
                            // next read bit leaves at this same edge [R3]
                            sdo_nxt   = shout_r[DATA_W-1]; // [R3]
                            shout_nxt = {shout_r[DATA_W-2:0], 1'b0};
                        end
                        if (cnt_r == CNT_W'(HDR_BITS - 1)) begin
                            state_nxt = RSP_DATA;
                            // only the header byte has arrived: it is word low
                            if (word[ADDR_W-1:0] < ADDR_LIMIT) begin
                                shout_nxt = regs_r[word[IDX_W-1:0]];
                            end else begin
                                shout_nxt = '0;
                            end
                        end
                        if (cnt_r == CNT_W'(FRAME_BITS - 1)) begin
                            state_nxt = RSP_DONE;
                            wr_nxt    = word[DIR_POS]
                                        && word[ADDR_MSB:ADDR_LSB] < ADDR_LIMIT;
                        end
                    end
                end
                RSP_DONE: begin
                    // extra clocks inside one select period are ignored [R8]
                    state_nxt = RSP_DONE;
                end
                default: state_nxt = RSP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (port_clr) begin
            sclk_r  <= 1'b0;
            state_r <= RSP_IDLE;
            cnt_r   <= '0;
            shin_r  <= '0;
            shout_r <= '0;
            sdo_r   <= 1'b0;
            oe_r    <= 1'b0;
            wr_r    <= 1'b0;
        end else begin
            sclk_r  <= sclk_nxt;
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            shin_r  <= shin_nxt;
            shout_r <= shout_nxt;
            sdo_r   <= sdo_nxt;
            oe_r    <= oe_nxt;
            wr_r    <= wr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers steering the chains [R7]
    logic [IDX_W-1:0]           widx;
    wire  [NUM_REGS*DATA_W-1:0] cfg_nxt;
    assign widx = shin_r[ADDR_LSB +: IDX_W];
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            logic [DATA_W-1:0] reg_nxt;
            always_comb begin
                reg_nxt = regs_r[g];
                if (wr_r && widx == IDX_W'(g)) begin
                    reg_nxt = shin_r[DATA_W-1:0]; // [R7]
                end
            end
            always_ff @(posedge clk_i) begin
                if (port_clr) begin
                    regs_r[g] <= REG_RESET; // [R5]
                end else begin
                    regs_r[g] <= reg_nxt;
                end
            end
            // flat copy so one process owns the whole output bus
            assign cfg_nxt[g*DATA_W +: DATA_W] = reg_nxt;
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (port_clr) begin
            write_strobe_o <= 1'b0;
            config_o       <= {NUM_REGS{REG_RESET}}; // [R5]
        end else begin
            write_strobe_o <= wr_r;
            config_o       <= cfg_nxt; // [R7]
        end
    end

    assign serial_out_line_o    = sdo_r;
    assign serial_out_line_oe_o = oe_r;
endmodule : rsp_port
`default_nettype wire

//--- tb/rsp_port_asserts.sv
// Purpose: port checks for rsp_port
// Assumes: link half period of 16 clk_i cycles
// Notes: bound into every rsp_port
`timescale 1ns/1ps
`default_nettype none
module rsp_port_chk
    import rsp_pkg::*;
(
    input wire logic                       clk_i,
    input wire logic                       rst_n_i,
    input wire logic                       port_reset_n_i,
    input wire logic                       port_select_n_i,
    input wire logic                       serial_clock_line_i,
    input wire logic                       serial_in_line_i,
    input wire logic                       serial_out_line_o,
    input wire logic                       serial_out_line_oe_o,
    input wire logic [NUM_REGS*DATA_W-1:0] config_o,
    input wire logic                       write_strobe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_rst_clear: assert property ($rose(rst_n_i) |-> config_o == '0
        && !serial_out_line_oe_o && !write_strobe_o) else $error("rst");
    chk_port_clear: assert property (!port_reset_n_i [*4] |=>
        config_o == '0 && !write_strobe_o) else $error("port rst");
    chk_oe_idle: assert property (port_select_n_i [*4] |->
        !serial_out_line_oe_o) else $error("oe idle");
    chk_oe_start: assert property ($fell(port_select_n_i)
        && port_reset_n_i |-> ##[2:5] serial_out_line_oe_o) else $error("oe");
    chk_cfg_quiet: assert property ((port_select_n_i && port_reset_n_i)
        [*8] |=> $stable(config_o)) else $error("cfg");
    chk_strobe_pulse: assert property (write_strobe_o |=>
        !write_strobe_o) else $error("strobe");
    chk_strobe_edge: assert property (write_strobe_o |->
        serial_clock_line_i && !$past(serial_clock_line_i, 12))
        else $error("edge");
    chk_out_hold: assert property ((!serial_clock_line_i &&
        !port_select_n_i) [*6] |=> $stable(serial_out_line_o))
        else $error("out");
endmodule : rsp_port_chk
bind rsp_port rsp_port_chk u_chk (.*);
`default_nettype wire

//--- tb/rsp_master.sv
// Purpose: serial master driving the port
// Assumes: link clock idles low, 160 ns period
// Notes: data line inverted once released
`timescale 1ns/1ps
`default_nettype none
module rsp_master (
    output logic      sck_o,
    output logic      sel_n_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    initial begin
        sck_o = 1'b0;
        sel_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // skip keeps select high, to prove deselected traffic is ignored
    task automatic xfer(input logic [23:0] w, input logic skip,
                        output logic [15:0] rd);
        rd = 16'h0000;
        sel_n_o = skip;
        #40;
        for (int k = 23; k >= 0; k--) begin
            sdi_o = w[k];
            #80 sck_o = 1'b1;
            #80 if (k < 16) rd = {rd[14:0], sdo_i};
            sck_o = 1'b0;
        end
        #40 sel_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #40;
    endtask : xfer
endmodule : rsp_master
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench for rsp_port
// Assumes: expected registers kept in a shadow array
// Notes: frames start 1 ns after a clk_i edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rsp_pkg::*;
    logic                       clk_i, rst_n_i, port_reset_n_i;
    logic                       sck, sel_n, sdi, sdo, sdo_oe, write_strobe_o;
    logic [NUM_REGS*DATA_W-1:0] config_o;
    logic [DATA_W-1:0]          shadow [NUM_REGS];
    int                         failures, checks_done, strobes, oe_hits;
    logic [15:0]                rd;
    logic                       sdo_pin;
    // released out line reads inverted so a late enable shows up
    assign sdo_pin = sdo_oe ? sdo : ~sdo;
    rsp_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .port_reset_n_i(port_reset_n_i), .port_select_n_i(sel_n),
        .serial_clock_line_i(sck), .serial_in_line_i(sdi),
        .serial_out_line_o(sdo), .serial_out_line_oe_o(sdo_oe),
        .config_o(config_o), .write_strobe_o(write_strobe_o));
    rsp_master m (.sck_o(sck), .sel_n_o(sel_n), .sdi_o(sdi),
        .sdo_i(sdo_pin));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (write_strobe_o === 1'b1) strobes++;
        if (sdo_oe === 1'b1) oe_hits++;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic frame(input logic [23:0] w, input logic skip);
        @(posedge clk_i);
        #1 m.xfer(w, skip, rd);
    endtask : frame
    task automatic cfg_all;
        for (int i = 0; i < NUM_REGS; i++)
            check(config_o[i*DATA_W +: DATA_W], shadow[i]);
    endtask : cfg_all
    // refused addresses must neither strobe nor read back
    task automatic wr_rd(input logic [6:0] a, input logic [15:0] d);
        int n;
        n = strobes;
        frame({1'b1, a, d}, 1'b0);
        if (a < ADDR_LIMIT) shadow[a[IDX_W-1:0]] = d;
        check(strobes - n, a < ADDR_LIMIT);
        cfg_all();
        frame({1'b0, a, 16'h0000}, 1'b0);
        check(rd, (a < ADDR_LIMIT) ? d : 16'h0000);
    endtask : wr_rd
    task automatic test_deselect;
        int n, o;
        n = strobes;
        o = oe_hits;
        frame({1'b1, 7'h02, 16'h5A5A}, 1'b1);
        check(strobes - n + oe_hits - o, 0);
        cfg_all();
    endtask : test_deselect
    task automatic test_port_reset;
        @(posedge clk_i);
        #1 port_reset_n_i = 1'b0;
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < NUM_REGS; i++) shadow[i] = REG_RESET;
        cfg_all();
        check(sdo_oe, 1'b0);
        #1 port_reset_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        wr_rd(7'h03, 16'h3C3C);
    endtask : test_port_reset
    task automatic test_done;
        $display("failures=%0d checks=%0d", failures, checks_done);
        if (failures == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////
    initial begin
        rst_n_i = 1'b0;
        port_reset_n_i = 1'b1;
        for (int i = 0; i < NUM_REGS; i++) shadow[i] = REG_RESET;
        repeat (8) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        cfg_all();
        wr_rd(7'h00, 16'hA5C3);
        wr_rd(7'h0F, 16'h8001);
        wr_rd(7'h05, 16'hFFFF);
        wr_rd(7'h05, 16'h0000);
        wr_rd(7'h10, 16'hFFFF);
        wr_rd(7'h7F, 16'h1234);
        test_deselect();
        test_port_reset();
        test_done();
    end
    initial begin
        #200_000;
        failures++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
